// ===== hdl/tcc_pkg.sv
`default_nettype none
package tcc_pkg;
  localparam int NCH = 4;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;

  localparam logic [7:0] ADDR_SLOT_FUNCTION    = 8'hc1;
  localparam logic [7:0] ADDR_SLOT1_LOW        = 8'hc2;
  localparam logic [7:0] ADDR_SLOT1_HIGH       = 8'hc3;
  localparam logic [7:0] ADDR_SLOT2_LOW        = 8'hc4;
  localparam logic [7:0] ADDR_SLOT2_HIGH       = 8'hc5;
  localparam logic [7:0] ADDR_SLOT3_LOW        = 8'hc6;
  localparam logic [7:0] ADDR_SLOT3_HIGH       = 8'hc7;
  localparam logic [7:0] ADDR_RELOAD_LOW       = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH      = 8'hcb;
  localparam logic [7:0] ADDR_IRQ_ENABLE       = 8'hd2;
  localparam logic [7:0] ADDR_EVENT_FLAGS      = 8'hd3;
  localparam logic [7:0] ADDR_TRIGGER_SELECT   = 8'hdd;

  // Channel index 0 is the reload/capture channel, 1..3 the slots
  localparam logic [3:0][7:0] CH_LOW_ADDR  = {ADDR_SLOT3_LOW, ADDR_SLOT2_LOW,
                                              ADDR_SLOT1_LOW, ADDR_RELOAD_LOW};
  localparam logic [3:0][7:0] CH_HIGH_ADDR = {ADDR_SLOT3_HIGH, ADDR_SLOT2_HIGH,
                                              ADDR_SLOT1_HIGH, ADDR_RELOAD_HIGH};

  localparam int OVF_BIT = 7;
  localparam int FIELD_W = 2;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [3:0]  NIB_RESET  = 4'h0;

  typedef enum logic [1:0] {
    TRIG_WRITE = 2'b00,
    TRIG_RISE  = 2'b01,
    TRIG_FALL  = 2'b10,
    TRIG_BOTH  = 2'b11
  } tcc_trig_t;

  typedef enum logic [1:0] {
    FN_OFF      = 2'b00,
    FN_CAPTURE  = 2'b01,
    FN_COMPARE  = 2'b10,
    FN_RESERVED = 2'b11
  } tcc_fn_t;
endpackage
`default_nettype wire

// ===== hdl/tcc_capture_compare.sv
// Behaviour
// - Slot3 trigger: low-byte write, rising, falling or either edge of input d.
// - Slot2 trigger: same four codes using input c.
// - Slot1 trigger: same four codes using input b.
// - Reload/capture trigger: same four codes using input a.
// - Overflow interrupt requested only while enable bit 7 is one.
// - Enable bits 3..0 gate channel d, c, b, a interrupts.
// - Overflow flag bit 7 set on timer overflow, held until software clears.
// - Channel flags set by selected edge or compare match; only software clears.
// - Each slot holds 16 bits as separate high and low byte registers.
// - Reload/capture channel holds 16 bits as high and low byte registers.
// - Function field: 00 off, 01 capture, 10 compare, 11 reserved.
// - Captured value is the 16-bit timer count from its two bytes.
`timescale 1ns/100ps
`default_nettype none
module tcc_capture_compare
  import tcc_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic [7:0]         sfr_addr,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire logic [BYTE_W-1:0]  sfr_wdata,
  output var  logic [BYTE_W-1:0]  sfr_rdata,
  input  wire logic [BYTE_W-1:0]  timer_count_high,
  input  wire logic [BYTE_W-1:0]  timer_count_low,
  input  wire logic               timer_overflow,
  input  wire logic               capture_in_a,
  input  wire logic               capture_in_b,
  input  wire logic               capture_in_c,
  input  wire logic               capture_in_d,
  output var  logic               overflow_irq,
  output var  logic [NCH-1:0]     chan_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [CNT_W-1:0]  val_r [NCH];
  logic [CNT_W-1:0]  val_nxt [NCH];
  logic [7:0]        trig_sel_r, trig_sel_nxt;
  logic [7:0]        func_r, func_nxt;
  logic              ovf_en_r, ovf_en_nxt;
  logic [NCH-1:0]    chan_en_r, chan_en_nxt;
  logic              ovf_flag_r, ovf_flag_nxt;
  logic [NCH-1:0]    chan_flag_r, chan_flag_nxt;
  logic [NCH-1:0]    prev_r, prev_nxt;
  logic              arm_r, arm_nxt;
  logic [BYTE_W-1:0] rdata_r, rdata_nxt;
  logic              ovf_irq_r, ovf_irq_nxt;
  logic [NCH-1:0]    chan_irq_r, chan_irq_nxt;
  logic [NCH-1:0]    pins;
  logic [CNT_W-1:0]  count;

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] target);
    return wr && (a == target);
  endfunction

  assign pins  = {capture_in_d, capture_in_c, capture_in_b, capture_in_a};
  assign count = {timer_count_high, timer_count_low};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic      rise;
    logic      fall;
    logic      pin_ev;
    logic      wr_low;
    tcc_trig_t sel;
    tcc_fn_t   fn;
    rise = 1'b0;
    fall = 1'b0;
    pin_ev = 1'b0;
    wr_low = 1'b0;
    sel = TRIG_WRITE;
    fn = FN_OFF;
    trig_sel_nxt  = trig_sel_r;
    func_nxt      = func_r;
    ovf_en_nxt    = ovf_en_r;
    chan_en_nxt   = chan_en_r;
    ovf_flag_nxt  = ovf_flag_r;
    chan_flag_nxt = chan_flag_r;
    prev_nxt      = pins;
    // First cycle after reset only loads the pin history, so no false edge
    arm_nxt       = 1'b1;
    if (wr_hit(sfr_wr, sfr_addr, ADDR_TRIGGER_SELECT)) begin
      trig_sel_nxt = sfr_wdata;
    end
    if (wr_hit(sfr_wr, sfr_addr, ADDR_SLOT_FUNCTION)) begin
      func_nxt = sfr_wdata;
    end
    if (wr_hit(sfr_wr, sfr_addr, ADDR_IRQ_ENABLE)) begin
      ovf_en_nxt  = sfr_wdata[OVF_BIT];
      chan_en_nxt = sfr_wdata[NCH-1:0];
    end
    // Writing zero clears a flag; a same-cycle event still sets it
    if (wr_hit(sfr_wr, sfr_addr, ADDR_EVENT_FLAGS)) begin
      ovf_flag_nxt  = ovf_flag_r & sfr_wdata[OVF_BIT];
      chan_flag_nxt = chan_flag_r & sfr_wdata[NCH-1:0];
    end
    if (timer_overflow) begin
      ovf_flag_nxt = 1'b1;
    end
    for (int k = 0; k < NCH; k++) begin
      val_nxt[k] = val_r[k];
      sel    = tcc_trig_t'(trig_sel_r[k*FIELD_W +: FIELD_W]);
      fn     = tcc_fn_t'(func_r[k*FIELD_W +: FIELD_W]);
      rise   = arm_r && pins[k] && !prev_r[k];
      fall   = arm_r && !pins[k] && prev_r[k];
      wr_low = wr_hit(sfr_wr, sfr_addr, CH_LOW_ADDR[k]);
      unique case (sel)
        TRIG_WRITE: pin_ev = 1'b0;
        TRIG_RISE:  pin_ev = rise;
        TRIG_FALL:  pin_ev = fall;
        TRIG_BOTH:  pin_ev = rise || fall;
      endcase
      if (wr_low) begin
        val_nxt[k][BYTE_W-1:0] = sfr_wdata;
      end
      if (wr_hit(sfr_wr, sfr_addr, CH_HIGH_ADDR[k])) begin
        val_nxt[k][CNT_W-1:BYTE_W] = sfr_wdata;
      end
      // Capture wins over the software byte write; reserved code does nothing
      if (fn == FN_CAPTURE) begin
        if ((sel == TRIG_WRITE) ? wr_low : pin_ev) begin
          val_nxt[k] = count;
        end
        if (pin_ev) begin
          chan_flag_nxt[k] = 1'b1;
        end
      end
      // Match is a level; the flag re-sets while the count stays equal
      if (fn == FN_COMPARE && count == val_r[k]) begin
        chan_flag_nxt[k] = 1'b1;
      end
    end
    ovf_irq_nxt  = ovf_flag_r && ovf_en_r;
    chan_irq_nxt = chan_flag_r & chan_en_r;
    rdata_nxt = BYTE_RESET;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_SLOT_FUNCTION:  rdata_nxt = func_r;
        ADDR_TRIGGER_SELECT: rdata_nxt = trig_sel_r;
        ADDR_IRQ_ENABLE:     rdata_nxt = {ovf_en_r, 3'b000, chan_en_r};
        ADDR_EVENT_FLAGS:    rdata_nxt = {ovf_flag_r, 3'b000, chan_flag_r};
        ADDR_RELOAD_LOW:     rdata_nxt = val_r[0][BYTE_W-1:0];
        ADDR_RELOAD_HIGH:    rdata_nxt = val_r[0][CNT_W-1:BYTE_W];
        ADDR_SLOT1_LOW:      rdata_nxt = val_r[1][BYTE_W-1:0];
        ADDR_SLOT1_HIGH:     rdata_nxt = val_r[1][CNT_W-1:BYTE_W];
        ADDR_SLOT2_LOW:      rdata_nxt = val_r[2][BYTE_W-1:0];
        ADDR_SLOT2_HIGH:     rdata_nxt = val_r[2][CNT_W-1:BYTE_W];
        ADDR_SLOT3_LOW:      rdata_nxt = val_r[3][BYTE_W-1:0];
        ADDR_SLOT3_HIGH:     rdata_nxt = val_r[3][CNT_W-1:BYTE_W];
        default:             rdata_nxt = BYTE_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < NCH; k++) begin
        val_r[k] <= CNT_RESET;
      end
      trig_sel_r  <= BYTE_RESET;
      func_r      <= BYTE_RESET;
      ovf_en_r    <= 1'b0;
      chan_en_r   <= NIB_RESET;
      ovf_flag_r  <= 1'b0;
      chan_flag_r <= NIB_RESET;
      prev_r      <= NIB_RESET;
      arm_r       <= 1'b0;
      rdata_r     <= BYTE_RESET;
      ovf_irq_r   <= 1'b0;
      chan_irq_r  <= NIB_RESET;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        val_r[k] <= val_nxt[k];
      end
      trig_sel_r  <= trig_sel_nxt;
      func_r      <= func_nxt;
      ovf_en_r    <= ovf_en_nxt;
      chan_en_r   <= chan_en_nxt;
      ovf_flag_r  <= ovf_flag_nxt;
      chan_flag_r <= chan_flag_nxt;
      prev_r      <= prev_nxt;
      arm_r       <= arm_nxt;
      rdata_r     <= rdata_nxt;
      ovf_irq_r   <= ovf_irq_nxt;
      chan_irq_r  <= chan_irq_nxt;
    end
  end

  assign sfr_rdata    = rdata_r;
  assign overflow_irq = ovf_irq_r;
  assign chan_irq     = chan_irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  slot3_rise_a: assert property (
    (func_r[7:6] == FN_CAPTURE && trig_sel_r[7:6] == TRIG_RISE && arm_r && capture_in_d && !prev_r[3])
    |=> val_r[3] == $past(count) && chan_flag_r[3])
    else $error("slot3 rising capture missed");

  slot2_fall_a: assert property (
    (func_r[5:4] == FN_CAPTURE && trig_sel_r[5:4] == TRIG_FALL && arm_r && !capture_in_c && prev_r[2])
    |=> val_r[2] == $past(count))
    else $error("slot2 falling capture missed");

  slot1_both_a: assert property (
    (func_r[3:2] == FN_CAPTURE && trig_sel_r[3:2] == TRIG_BOTH && arm_r && (capture_in_b != prev_r[1]))
    |=> val_r[1] == $past(count))
    else $error("slot1 either-edge capture missed");

  reload_write_a: assert property (
    (func_r[1:0] == FN_CAPTURE && trig_sel_r[1:0] == TRIG_WRITE && sfr_wr && sfr_addr == ADDR_RELOAD_LOW)
    |=> val_r[0] == $past(count) && $stable(chan_flag_r[0]))
    else $error("reload write capture missed");

  ovf_irq_gate_a: assert property (
    !ovf_en_r [*2] |-> !overflow_irq)
    else $error("overflow request while disabled");

  chan_irq_gate_a: assert property (
    chan_flag_r[2] && chan_en_r[2] |=> chan_irq[2])
    else $error("channel c request not raised");

  ovf_set_a: assert property (
    timer_overflow |=> ovf_flag_r ##1 (ovf_flag_r || $past(sfr_wr && sfr_addr == ADDR_EVENT_FLAGS)))
    else $error("overflow flag not held");

  flag_hold_a: assert property (
    chan_flag_r[0] && !(sfr_wr && sfr_addr == ADDR_EVENT_FLAGS) |=> chan_flag_r[0])
    else $error("channel flag cleared by hardware");

  high_byte_a: assert property (
    sfr_wr && sfr_addr == ADDR_SLOT1_HIGH && func_r[3:2] != FN_CAPTURE
    |=> val_r[1][15:8] == $past(sfr_wdata))
    else $error("high byte write lost");

  compare_flag_a: assert property (
    func_r[3:2] == FN_COMPARE && count == val_r[1] |=> chan_flag_r[1] ##1 chan_irq[1] == $past(chan_en_r[1]))
    else $error("compare match flag missed");

  inactive_a: assert property (
    func_r[7:6] == FN_OFF && !(sfr_wr && (sfr_addr == ADDR_SLOT3_LOW || sfr_addr == ADDR_SLOT3_HIGH))
    |=> $stable(val_r[3]))
    else $error("inactive slot changed");

endmodule // tcc_capture_compare
`default_nettype wire

// ===== dv/tcc_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_far_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] pin_lvl,
  input  wire logic       jump,
  output var  logic [7:0] timer_count_high,
  output var  logic [7:0] timer_count_low,
  output var  logic       timer_overflow,
  output var  logic [3:0] pins
);
  logic [15:0] cnt_r;
  // Jump lands near the wrap so overflow needs no 64k-cycle run
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      timer_overflow <= 1'b0;
    end else begin
      cnt_r <= jump ? 16'hfff8 : cnt_r + 16'h0001;
      timer_overflow <= (cnt_r == 16'hffff) && !jump;
    end
  end
  assign {timer_count_high, timer_count_low} = cnt_r;
  assign pins = pin_lvl;
endmodule // tcc_far_model
`default_nettype wire

// ===== dv/tcc_capture_compare_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_capture_compare_tb;
  import tcc_pkg::*;
  logic        sys_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, jump = 0;
  logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata, cnt_h, cnt_l, flg, en;
  logic        timer_overflow, overflow_irq;
  logic [3:0]  pin_lvl = 0, pins, chan_irq;
  logic [15:0] lfsr = 16'h0012, wcnt, tgt;
  logic [15:0] exp_v [4];
  int          n_fail = 0, num_checks = 0;
  always #20 sys_clk = ~sys_clk;
  tcc_far_model far (.sys_clk(sys_clk), .rst(rst), .pin_lvl(pin_lvl), .jump(jump), .timer_count_high(cnt_h),
    .timer_count_low(cnt_l), .timer_overflow(timer_overflow), .pins(pins));
  tcc_capture_compare dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_count_high(cnt_h), .timer_count_low(cnt_l),
    .timer_overflow(timer_overflow), .capture_in_a(pins[0]), .capture_in_b(pins[1]), .capture_in_c(pins[2]),
    .capture_in_d(pins[3]), .overflow_irq(overflow_irq), .chan_irq(chan_irq));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    wcnt = {cnt_h, cnt_l};
    @(posedge sys_clk) #1;
    sfr_wr = 0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk) #1;
    sfr_addr = a;
    sfr_rd = 1;
    @(posedge sys_clk) #1;
    sfr_rd = 0;
    chk(what, exp, sfr_rdata);
  endtask
  task automatic vchk(input int ch);
    rchk("value low", CH_LOW_ADDR[ch], exp_v[ch][7:0]);
    rchk("value high", CH_HIGH_ADDR[ch], exp_v[ch][15:8]);
    rchk("flags", ADDR_EVENT_FLAGS, flg);
  endtask
  task automatic pin_step(input int ch, input logic lvl, input logic hit);
    @(posedge sys_clk) #1;
    pin_lvl[ch] = lvl;
    if (hit) begin
      exp_v[ch] = {cnt_h, cnt_l};
      flg[ch] = 1'b1;
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #(40 * 6000);
    n_fail++;
    conclude();
  end
  initial begin
    flg = 8'h00;
    repeat (6) @(posedge sys_clk);
    #1 rst = 0;
    for (int k = 0; k < 4; k++) begin
      exp_v[k] = 16'h0000;
      vchk(k);
    end
    rchk("irq enable", ADDR_IRQ_ENABLE, 8'h00);
    rchk("trigger select", ADDR_TRIGGER_SELECT, 8'h00);
    wr(8'hc0, 8'hff);
    rchk("unmapped", 8'hc0, 8'h00);
    // Function off: low-byte writes store data, nothing is captured
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_step(lfsr);
      wr(CH_HIGH_ADDR[k], lfsr[15:8]);
      wr(CH_LOW_ADDR[k], lfsr[7:0]);
      exp_v[k] = lfsr;
      vchk(k);
    end
    wr(ADDR_SLOT_FUNCTION, 8'h55);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_TRIGGER_SELECT, {4{m[1:0]}});
      for (int ch = 0; ch < 4; ch++) begin
        if (m == 0) begin
          lfsr = lfsr_step(lfsr);
          wr(CH_LOW_ADDR[ch], lfsr[7:0]);
          exp_v[ch] = wcnt;
          vchk(ch);
        end else begin
          for (int e = 1; e >= 0; e--) begin
            pin_step(ch, e[0], (m == 3) || (m == 1 && e == 1) || (m == 2 && e == 0));
            vchk(ch);
          end
        end
      end
    end
    wr(ADDR_EVENT_FLAGS, 8'h0e);
    flg = 8'h0e;
    wr(ADDR_SLOT_FUNCTION, 8'h00);
    pin_step(3, 1'b1, 1'b0);
    pin_step(3, 1'b0, 1'b0);
    vchk(3);
    @(posedge sys_clk) #1 jump = 1;
    @(posedge sys_clk) #1 jump = 0;
    repeat (14) @(posedge sys_clk);
    flg[7] = 1'b1;
    rchk("overflow flag", ADDR_EVENT_FLAGS, flg);
    // Reserved enable bits read back as zero
    for (int i = 0; i < 2; i++) begin
      en = (i != 0) ? 8'hfa : 8'h75;
      wr(ADDR_IRQ_ENABLE, en);
      rchk("irq enable", ADDR_IRQ_ENABLE, en & 8'h8f);
      chk("channel irq", {4'h0, flg[3:0] & en[3:0]}, {4'h0, chan_irq});
      chk("overflow irq", {7'h00, en[7]}, {7'h00, overflow_irq});
    end
    wr(ADDR_EVENT_FLAGS, 8'h00);
    flg = 8'h00;
    rchk("flags cleared", ADDR_EVENT_FLAGS, flg);
    chk("irq after clear", 8'h00, {3'h0, overflow_irq, chan_irq});
    wr(ADDR_SLOT_FUNCTION, 8'h08);
    tgt = {cnt_h, cnt_l} + 16'h0028;
    wr(ADDR_SLOT1_HIGH, tgt[15:8]);
    wr(ADDR_SLOT1_LOW, tgt[7:0]);
    repeat (45) @(posedge sys_clk);
    flg[1] = 1'b1;
    rchk("compare flag", ADDR_EVENT_FLAGS, flg);
    chk("compare irq", 8'h02, {4'h0, chan_irq});
    // Reserved function code: pin edges ignored, low-byte write stores data
    wr(ADDR_SLOT_FUNCTION, 8'hc0);
    pin_step(3, 1'b1, 1'b0);
    pin_step(3, 1'b0, 1'b0);
    lfsr = lfsr_step(lfsr);
    wr(ADDR_SLOT3_LOW, lfsr[7:0]);
    exp_v[3][7:0] = lfsr[7:0];
    vchk(3);
    conclude();
  end
endmodule // tcc_capture_compare_tb
`default_nettype wire
